// >>> core/msc_pkg.sv
// constants and types for the measure, scan-count, temperature and sleep logic
// assumes a 25 MHz core clock and commands already decoded from the link
package msc_pkg;
   localparam int unsigned MCLK_PERIOD_NS  = 40;
   localparam int unsigned BIAS_DWELL_NS   = 2500000;
   localparam int unsigned DWELL_CYCLES    = (BIAS_DWELL_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int unsigned SLEEP_MAX_NS    = 4000000;
   localparam int unsigned SLEEP_MAX_CYCLES = SLEEP_MAX_NS / MCLK_PERIOD_NS;
   // 500us at 500 kHz .. 4000us at 62.5 kHz is 250 bit times at every rate
   localparam int unsigned SLEEP_WAIT_BITS = 250;
   localparam int unsigned TMR_W           = 17;

   localparam logic [5:0]  SFX_PACK     = 6'h00;
   localparam logic [5:0]  SFX_CELL1    = 6'h01;
   localparam logic [5:0]  SFX_CELL12   = 6'h0c;
   localparam logic [5:0]  SFX_INT_TEMP = 6'h10;
   localparam logic [5:0]  SFX_EXT1     = 6'h11;
   localparam logic [5:0]  SFX_EXT4     = 6'h14;
   localparam logic [5:0]  SFX_REF_RAW  = 6'h15;
   localparam int unsigned RES_DEPTH    = 22;
   localparam int unsigned RES_W        = 14;

   localparam logic [1:0]  PAGE_CFG       = 2'h1;
   localparam logic [1:0]  PAGE_RESULT    = 2'h2;
   localparam logic [5:0]  ADDR_RCPT_CNT  = 6'h16;
   localparam logic [5:0]  ADDR_TEMP_FLT  = 6'h30;
   localparam logic [5:0]  ADDR_TEMP_CHK  = 6'h31;
   localparam logic [3:0]  RCPT_CNT_RST   = 4'h0;
   localparam logic [3:0]  TEMP_CHK_RST   = 4'h0;

   typedef enum logic [2:0] {
      MSC_CMD_MEASURE   = 3'h0,
      MSC_CMD_SCAN_VOLT = 3'h1,
      MSC_CMD_SCAN_TEMP = 3'h2,
      MSC_CMD_SCAN_WIRE = 3'h3,
      MSC_CMD_SCAN_ALL  = 3'h4,
      MSC_CMD_SLEEP     = 3'h5,
      MSC_CMD_WAKEUP    = 3'h6,
      MSC_CMD_OTHER     = 3'h7
   } msc_cmd_t;

   typedef enum logic [2:0] {
      MSC_ST_IDLE  = 3'b001,
      MSC_ST_DWELL = 3'b010,
      MSC_ST_CONV  = 3'b100
   } msc_state_t;
endpackage : msc_pkg

// >>> core/msc_measure_sleep_command_logic.sv
// measure command, receipt counter, temperature sequence and sleep entry
// assumes cmd_* and port1_comm_valid are mclk pulses from the frame decoder,
// adc_* is a same-clock converter port and link_clk is the raw chain clock
//
// Notes on behaviour
// R01: own-address measure counts and starts measurement
// R02: six-bit suffix picks the measured element
// R03: 0x00 pack, 0x01..0x0c cells 1..12
// R04: 0x10 internal, 0x11..0x14 external, 0x15 reference
// R05: one conversion stored; host reads it later
// R06: back to standby after the measurement
// R07: four-bit receipt counter at page 1, 0x16
// R08: counter adds one per scan/measure, wraps
// R09: busy: new request ignored, still counted
// R10: host compares counter before and after
// R11: bias on, 2.5 ms dwell, convert, bias off
// R12: fourteen-bit temperature result per input register
// R13: per-input check enables, reset zero, low faults
// R14: sleep keeps only comms, slow oscillator, registers
// R15: individually addressed sleep ignored, answered nak
// R16: top device acks a valid sleep
// R17: host-port traffic during wait cancels sleep
// R18: repeated sleep restarts the wait timers
// R19: wait bounded by 250 link bit times
// R20: no comms timeout check for sleep
// R21: wait expiry or watchdog puts device asleep
// R22: only valid wakeup leaves sleep
`timescale 1ns/10ps
module msc_measure_sleep_command_logic #(
   parameter int unsigned DWELL_CYCLES     = msc_pkg::DWELL_CYCLES,
   parameter int unsigned SLEEP_MAX_CYCLES = msc_pkg::SLEEP_MAX_CYCLES,
   parameter int unsigned SLEEP_WAIT_BITS  = msc_pkg::SLEEP_WAIT_BITS
) (
   // clock and reset
   input  wire logic                       mclk,
   input  wire logic                       resetn,
   // decoded commands
   input  wire logic                       cmd_valid,
   input  wire msc_pkg::msc_cmd_t          cmd_kind,
   input  wire logic [5:0]                 cmd_suffix,
   input  wire logic                       cmd_to_me,
   input  wire logic                       cmd_broadcast,
   input  wire logic                       port1_comm_valid,
   input  wire logic                       is_top,
   input  wire logic                       watchdog_expired,
   // chain clock, raw
   input  wire logic                       link_clk,
   // responses
   output logic                            resp_ack,
   output logic                            resp_nak,
   // converter
   output logic                            adc_start,
   output logic [5:0]                      adc_sel,
   input  wire logic                       adc_done,
   input  wire logic [msc_pkg::RES_W-1:0]  adc_data,
   input  wire logic [msc_pkg::RES_W-1:0]  ext_temp_threshold,
   // other scan engine
   output logic                            scan_start,
   output msc_pkg::msc_cmd_t               scan_kind,
   input  wire logic                       scan_busy,
   // status
   output logic                            thermistor_bias_output,
   output logic                            op_busy,
   output logic                            sleep_pending,
   output logic                            sleep_mode,
   output logic                            main_power_en,
   output logic                            comm_timeout_check_en,
   output logic [3:0]                      temp_fault,
   // register port
   input  wire logic                       rd_en,
   input  wire logic [1:0]                 rd_page,
   input  wire logic [5:0]                 rd_addr,
   output logic [msc_pkg::RES_W-1:0]       rd_data,
   input  wire logic                       wr_en,
   input  wire logic [1:0]                 wr_page,
   input  wire logic [5:0]                 wr_addr,
   input  wire logic [msc_pkg::RES_W-1:0]  wr_data
);

   // element codes that name a real measurement
   function automatic logic sfx_valid(input logic [5:0] s);
      sfx_valid = (s <= msc_pkg::SFX_CELL12) ||                          // [R03]
                  (s >= msc_pkg::SFX_INT_TEMP && s <= msc_pkg::SFX_REF_RAW); // [R04]
   endfunction : sfx_valid

   // external temperature input codes
   function automatic logic sfx_ext(input logic [5:0] s);
      sfx_ext = (s >= msc_pkg::SFX_EXT1) && (s <= msc_pkg::SFX_EXT4);
   endfunction : sfx_ext

   // sequencer, timers and register state
   msc_pkg::msc_state_t             state_reg, state_next;
   logic [msc_pkg::TMR_W-1:0]       tmr_reg, slp_tmr_reg;
   logic [7:0]                      bit_cnt_reg;
   logic [5:0]                      sel_reg;
   logic                            seq_reg, bias_reg, start_reg;
   logic                            sstart_reg, ack_reg, nak_reg;
   msc_pkg::msc_cmd_t               skind_reg;
   logic                            pend_reg, asleep_reg;
   logic [3:0]                      cnt_reg, chk_reg, flt_reg;
   logic [msc_pkg::RES_W-1:0]       rdat_reg;
   logic [msc_pkg::RES_W-1:0]       res_mem [0:msc_pkg::RES_DEPTH-1];
   logic                            lk_s1, lk_s2, lk_s3;

   // command decode
   wire is_meas   = cmd_valid && cmd_kind == msc_pkg::MSC_CMD_MEASURE && cmd_to_me; // [R01]
   wire is_scan   = cmd_valid && (cmd_to_me || cmd_broadcast) &&
                    (cmd_kind == msc_pkg::MSC_CMD_SCAN_VOLT ||
                     cmd_kind == msc_pkg::MSC_CMD_SCAN_TEMP ||
                     cmd_kind == msc_pkg::MSC_CMD_SCAN_WIRE ||
                     cmd_kind == msc_pkg::MSC_CMD_SCAN_ALL);

   // receipt count and busy gating
   wire counted   = is_meas || is_scan;                                  // [R08]
   wire busy      = state_reg != msc_pkg::MSC_ST_IDLE || scan_busy || sstart_reg;
   wire free_go   = counted && !busy;                                    // [R09]
   wire go_meas   = free_go && is_meas && sfx_valid(cmd_suffix);         // [R02]
   wire go_tscan  = free_go && cmd_kind == msc_pkg::MSC_CMD_SCAN_TEMP;
   wire go_other  = free_go && is_scan && cmd_kind != msc_pkg::MSC_CMD_SCAN_TEMP;

   // temperature sequence
   wire need_bias = go_tscan || (go_meas && sfx_ext(cmd_suffix));        // [R11]
   wire dwell_end = tmr_reg == msc_pkg::TMR_W'(DWELL_CYCLES - 1);
   wire seq_more  = seq_reg && sel_reg != msc_pkg::SFX_EXT4;
   wire [1:0] ext_idx = 2'(sel_reg - msc_pkg::SFX_EXT1);

   // low reading on an enabled input
   wire low_fault = adc_done && state_reg == msc_pkg::MSC_ST_CONV && sfx_ext(sel_reg) &&
                    chk_reg[ext_idx] && adc_data < ext_temp_threshold;   // [R13]
   wire [3:0] flt_set = low_fault ? (4'h1 << ext_idx) : 4'h0;

   // sleep entry and wakeup
   wire link_edge  = lk_s2 && !lk_s3;
   wire sleep_cmd  = cmd_valid && cmd_kind == msc_pkg::MSC_CMD_SLEEP && !asleep_reg;
   wire sleep_ok   = sleep_cmd && cmd_broadcast;
   wire sleep_nak  = sleep_cmd && !cmd_broadcast && cmd_to_me;           // [R15]
   wire wake_cmd   = cmd_valid && cmd_kind == msc_pkg::MSC_CMD_WAKEUP && cmd_broadcast;

   // bit count or time cap ends the wait
   wire wait_done  = pend_reg && ((link_edge &&
                     bit_cnt_reg == 8'(SLEEP_WAIT_BITS - 1)) ||
                     slp_tmr_reg == msc_pkg::TMR_W'(SLEEP_MAX_CYCLES - 1)); // [R19]

   // register port decode
   wire wr_cfg  = wr_en && wr_page == msc_pkg::PAGE_CFG;
   wire wr_chk  = wr_cfg && wr_addr == msc_pkg::ADDR_TEMP_CHK;
   wire [3:0] flt_clr = (wr_cfg && wr_addr == msc_pkg::ADDR_TEMP_FLT) ? wr_data[3:0] : 4'h0;

   // read side
   wire rd_cfg  = rd_page == msc_pkg::PAGE_CFG;
   wire rd_res  = rd_page == msc_pkg::PAGE_RESULT &&
                  rd_addr < 6'(msc_pkg::RES_DEPTH) && sfx_valid(rd_addr);
   wire [msc_pkg::RES_W-1:0] rd_mux =
        (rd_cfg && rd_addr == msc_pkg::ADDR_RCPT_CNT) ? {10'h000, cnt_reg} :   // [R07]
        (rd_cfg && rd_addr == msc_pkg::ADDR_TEMP_FLT) ? {10'h000, flt_reg} :
        (rd_cfg && rd_addr == msc_pkg::ADDR_TEMP_CHK) ? {10'h000, chk_reg} :
        rd_res ? res_mem[rd_addr[4:0]] : '0;

   // sequencer next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         msc_pkg::MSC_ST_IDLE: begin
            if (need_bias)
               state_next = msc_pkg::MSC_ST_DWELL;
            else if (go_meas)
               state_next = msc_pkg::MSC_ST_CONV;
         end

         msc_pkg::MSC_ST_DWELL: begin
            if (dwell_end)
               state_next = msc_pkg::MSC_ST_CONV;
         end

         msc_pkg::MSC_ST_CONV: begin
            if (adc_done && !seq_more)
               state_next = msc_pkg::MSC_ST_IDLE;                        // [R06]
         end
         default: state_next = msc_pkg::MSC_ST_IDLE;
      endcase
   end

   // sequencer registers, dwell timer, converter start
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= msc_pkg::MSC_ST_IDLE;
         tmr_reg   <= '0;
         sel_reg   <= msc_pkg::SFX_PACK;
         seq_reg   <= 1'b0;
         start_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         tmr_reg   <= (state_reg == msc_pkg::MSC_ST_DWELL) ? tmr_reg + 1'b1 : '0;

         start_reg <= (state_reg == msc_pkg::MSC_ST_IDLE && go_meas && !need_bias) ||
                      (state_reg == msc_pkg::MSC_ST_DWELL && dwell_end) ||
                      (state_reg == msc_pkg::MSC_ST_CONV && adc_done && seq_more);

         // element select; a temperature scan steps through the external inputs
         if (state_reg == msc_pkg::MSC_ST_IDLE && (go_meas || go_tscan)) begin
            sel_reg <= go_tscan ? msc_pkg::SFX_EXT1 : cmd_suffix;
            seq_reg <= go_tscan;
         end else if (state_reg == msc_pkg::MSC_ST_CONV && adc_done && seq_more) begin
            sel_reg <= sel_reg + 1'b1;                                   // [R11]
         end
      end
   end

   // one conversion lands in the element's own result word
   always_ff @(posedge mclk) begin
      if (state_reg == msc_pkg::MSC_ST_CONV && adc_done)
         res_mem[sel_reg[4:0]] <= adc_data;                              // [R05] [R12]
   end

   // bias, receipt count, enables, faults and read data
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bias_reg   <= 1'b0;
         cnt_reg    <= msc_pkg::RCPT_CNT_RST;
         chk_reg    <= msc_pkg::TEMP_CHK_RST;
         flt_reg    <= 4'h0;
         sstart_reg <= 1'b0;
         skind_reg  <= msc_pkg::MSC_CMD_OTHER;
         rdat_reg   <= '0;
      end else begin
         if (need_bias && state_reg == msc_pkg::MSC_ST_IDLE)
            bias_reg <= 1'b1;                                            // [R11]
         else if (state_reg == msc_pkg::MSC_ST_CONV && adc_done && !seq_more)
            bias_reg <= 1'b0;

         if (counted)
            cnt_reg <= cnt_reg + 1'b1;                                   // [R08] [R09]

         if (wr_chk)
            chk_reg <= wr_data[3:0];
         flt_reg    <= (flt_reg & ~flt_clr) | flt_set;                   // [R13]

         sstart_reg <= go_other;
         if (go_other)
            skind_reg <= cmd_kind;

         if (rd_en)
            rdat_reg <= rd_mux;
      end
   end

   // link edge detect and sleep entry
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         lk_s1       <= 1'b0;
         lk_s2       <= 1'b0;
         lk_s3       <= 1'b0;
         pend_reg    <= 1'b0;
         asleep_reg  <= 1'b0;
         bit_cnt_reg <= 8'h00;
         slp_tmr_reg <= '0;
         ack_reg     <= 1'b0;
         nak_reg     <= 1'b0;
      end else begin
         lk_s1   <= link_clk;
         lk_s2   <= lk_s1;
         lk_s3   <= lk_s2;

         ack_reg <= sleep_ok && is_top;                                  // [R16]
         nak_reg <= sleep_nak;

         // a fresh sleep request restarts both timers
         if (sleep_ok) begin
            pend_reg    <= 1'b1;                                         // [R18]
            bit_cnt_reg <= 8'h00;
            slp_tmr_reg <= '0;
         end else begin
            if (port1_comm_valid || wait_done || asleep_reg)
               pend_reg <= 1'b0;                                         // [R17]
            if (link_edge)
               bit_cnt_reg <= bit_cnt_reg + 1'b1;
            slp_tmr_reg <= slp_tmr_reg + 1'b1;
         end

         if (wake_cmd)
            asleep_reg <= 1'b0;                                          // [R22]
         else if ((wait_done && !port1_comm_valid) || watchdog_expired)
            asleep_reg <= 1'b1;                                          // [R21]
      end
   end

   // outputs
   assign resp_ack               = ack_reg;
   assign resp_nak               = nak_reg;

   assign adc_start              = start_reg;
   assign adc_sel                = sel_reg;

   assign scan_start             = sstart_reg;
   assign scan_kind              = skind_reg;

   assign thermistor_bias_output = bias_reg;
   assign op_busy                = busy;
   assign sleep_pending          = pend_reg;
   assign sleep_mode             = asleep_reg;
   assign main_power_en          = !asleep_reg;                          // [R14]
   assign comm_timeout_check_en  = !pend_reg;                            // [R20]
   assign temp_fault             = flt_reg;
   assign rd_data                = rdat_reg;
endmodule : msc_measure_sleep_command_logic

// >>> tb/msc_chk.sv
// checker for sleep entry, measure start and temperature sequencing
// sees only the ports of msc_measure_sleep_command_logic, bound below
`timescale 1ns/10ps
module msc_chk #(
   parameter int unsigned DWELL_CYCLES     = 20,
   parameter int unsigned SLEEP_MAX_CYCLES = 300,
   parameter int unsigned SLEEP_WAIT_BITS  = 8
) (
   // clock, reset and command side
   input wire logic              mclk, resetn, cmd_valid, cmd_to_me, cmd_broadcast,
   input wire logic              port1_comm_valid, is_top, watchdog_expired, adc_done,
   input wire msc_pkg::msc_cmd_t cmd_kind,
   input wire logic [5:0]        cmd_suffix, adc_sel,
   // design outputs
   input wire logic              resp_ack, resp_nak, adc_start, op_busy, sleep_pending,
   input wire logic              sleep_mode, thermistor_bias_output, comm_timeout_check_en
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   localparam int DW_LO = DWELL_CYCLES - 2;
   localparam int WMAX  = SLEEP_MAX_CYCLES + 2;
   wire slp_cmd = cmd_valid && cmd_kind == msc_pkg::MSC_CMD_SLEEP;
   wire slp_b   = slp_cmd && cmd_broadcast;
   wire slp_i   = slp_cmd && cmd_to_me && !cmd_broadcast;
   wire wake_b  = cmd_valid && cmd_kind == msc_pkg::MSC_CMD_WAKEUP && cmd_broadcast;
   wire meas    = cmd_valid && cmd_kind == msc_pkg::MSC_CMD_MEASURE && cmd_to_me;
   logic [16:0] wcnt;
   logic [16:0] bcnt;
   // cycles since the last sleep request, cycles with bias on
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wcnt <= '0;
         bcnt <= '0;
      end else begin
         wcnt <= (!sleep_pending || slp_b) ? '0 : wcnt + 17'h1;
         bcnt <= thermistor_bias_output ? bcnt + 17'h1 : '0;
      end
   end
   property p_meas; meas && !op_busy && cmd_suffix <= 6'h0c |=>
      adc_start && op_busy && adc_sel == $past(cmd_suffix); endproperty
   a_meas: assert property (p_meas) else $error("measure did not start");
   property p_busy; meas && op_busy && !thermistor_bias_output |=> !adc_start; endproperty
   a_busy: assert property (p_busy) else $error("busy measure started");
   property p_idle; adc_done && op_busy && !thermistor_bias_output && !cmd_valid |=> !op_busy;
   endproperty
   a_idle: assert property (p_idle) else $error("no return to standby");
   property p_dwell; adc_start && thermistor_bias_output |-> bcnt >= DW_LO; endproperty
   a_dwell: assert property (p_dwell) else $error("bias dwell too short");
   property p_boff; adc_done && adc_sel == msc_pkg::SFX_EXT4 && thermistor_bias_output
      |=> !thermistor_bias_output; endproperty
   a_boff: assert property (p_boff) else $error("bias left on");
   property p_nak; slp_i && !sleep_mode |=> resp_nak && !resp_ack; endproperty
   a_nak: assert property (p_nak) else $error("no nak on addressed sleep");
   property p_ack; slp_b && !sleep_mode |=> sleep_pending && !resp_nak
      && resp_ack == $past(is_top); endproperty
   a_ack: assert property (p_ack) else $error("sleep ack wrong");
   property p_cancel; sleep_pending && port1_comm_valid && !slp_b && !watchdog_expired
      |=> !sleep_pending && !sleep_mode; endproperty
   a_cancel: assert property (p_cancel) else $error("sleep not cancelled");
   property p_bound; sleep_pending |-> wcnt <= WMAX; endproperty
   a_bound: assert property (p_bound) else $error("sleep wait too long");
   property p_tmo; sleep_pending |-> !comm_timeout_check_en; endproperty
   a_tmo: assert property (p_tmo) else $error("timeout check during sleep wait");
   property p_wdog; watchdog_expired && !wake_b |=> sleep_mode; endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog did not sleep");
   property p_hold; sleep_mode && !wake_b |=> sleep_mode; endproperty
   a_hold: assert property (p_hold) else $error("left sleep without wakeup");
   property p_wake; sleep_mode && wake_b |=> !sleep_mode; endproperty
   a_wake: assert property (p_wake) else $error("wakeup ignored");
endmodule : msc_chk

bind msc_measure_sleep_command_logic msc_chk #(.DWELL_CYCLES(DWELL_CYCLES),
   .SLEEP_MAX_CYCLES(SLEEP_MAX_CYCLES), .SLEEP_WAIT_BITS(SLEEP_WAIT_BITS)) u_chk (
   .mclk, .resetn, .cmd_valid, .cmd_to_me, .cmd_broadcast, .port1_comm_valid, .is_top,
   .watchdog_expired, .adc_done, .cmd_kind, .cmd_suffix, .adc_sel, .resp_ack, .resp_nak,
   .adc_start, .op_busy, .sleep_pending, .sleep_mode, .thermistor_bias_output,
   .comm_timeout_check_en);

// >>> tb/msc_conv_model.sv
// converter and scan engine (voltage, wire and all scans) stand-ins for the command logic
// runs on the core clock; answers each start after a fixed latency
`timescale 1ns/10ps
module msc_conv_model #(
   parameter int unsigned LAT = 3
) (
   // converter port
   input  wire logic                  mclk,
   input  wire logic                  adc_start,
   input  wire logic [5:0]            adc_sel,
   output logic                       adc_done,
   output logic [msc_pkg::RES_W-1:0]  adc_data,
   // scan engine
   input  wire logic                  scan_start,
   output logic                       scan_busy
);
   logic [3:0] cnt = '0;
   logic [3:0] bcnt = '0;
   logic [5:0] sel_q = '0;
   initial adc_done = 1'b0;
   // data only meaningful with the done pulse
   assign adc_data  = adc_done ? {sel_q, 8'h5a} : ~{sel_q, 8'h5a};
   assign scan_busy = bcnt != 4'h0;
   always @(posedge mclk) begin
      adc_done <= cnt == 4'h1;
      if (adc_start) begin
         cnt <= 4'(LAT);
         sel_q <= adc_sel;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
      bcnt <= scan_start ? 4'h6 : (scan_busy ? bcnt - 4'h1 : 4'h0);
   end
endmodule : msc_conv_model

// >>> tb/msc_measure_sleep_command_logic_tb_top.sv
// self-checking bench for the measure, receipt-count and sleep logic
// needs msc_pkg, the design, its checker and the converter model
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module msc_measure_sleep_command_logic_tb_top;
   logic mclk = 0, resetn = 0, cmd_valid = 0, cmd_to_me = 0, cmd_broadcast = 0;
   logic port1_comm_valid = 0, is_top = 1, watchdog_expired = 0, link_clk = 0;
   logic link_run = 0, rd_en = 0, wr_en = 0, scan_start, scan_busy, adc_start, adc_done, seen;
   logic resp_ack, resp_nak, thermistor_bias_output, op_busy, sleep_pending, sleep_mode;
   logic main_power_en, comm_timeout_check_en;
   msc_pkg::msc_cmd_t cmd_kind = msc_pkg::MSC_CMD_OTHER, scan_kind;
   logic [5:0] cmd_suffix = '0, rd_addr = '0, wr_addr = '0, adc_sel;
   logic [1:0] rd_page = '0, wr_page = '0;
   logic [13:0] adc_data, rd_data, v, wr_data = '0, ext_temp_threshold = 14'h3fff;
   logic [3:0] temp_fault, exp_cnt = '0;
   int fails = 0, checks = 0, n_start = 0, t0;
   typedef struct packed {logic [5:0] sfx; logic ok; logic bias;} msc_row_t;
   // suffix, one conversion started, bias seen
   msc_row_t rows [10] = '{8'h02, 8'h06, 8'h32, 8'h42, 8'h47, 8'h53, 8'h56, 8'h34, 8'h58, 8'hfc};
   msc_measure_sleep_command_logic #(.DWELL_CYCLES(20), .SLEEP_MAX_CYCLES(300),
      .SLEEP_WAIT_BITS(8)) dut (.mclk, .resetn, .cmd_valid, .cmd_kind, .cmd_suffix,
      .cmd_to_me, .cmd_broadcast, .port1_comm_valid, .is_top, .watchdog_expired, .link_clk,
      .resp_ack, .resp_nak, .adc_start, .adc_sel, .adc_done, .adc_data, .ext_temp_threshold,
      .scan_start, .scan_kind, .scan_busy, .thermistor_bias_output, .op_busy, .sleep_pending,
      .sleep_mode, .main_power_en, .comm_timeout_check_en, .temp_fault, .rd_en, .rd_page,
      .rd_addr, .rd_data, .wr_en, .wr_page, .wr_addr, .wr_data);
   msc_conv_model u_conv (.mclk, .adc_start, .adc_sel, .adc_done, .adc_data, .scan_start,
      .scan_busy);
   initial forever #20 mclk = ~mclk;
   // chain clock stands still low outside traffic
   initial forever #160 link_clk = link_run & ~link_clk;
   always @(posedge mclk) if (adc_start === 1'b1) n_start++;
   task automatic cmd(msc_pkg::msc_cmd_t k, logic [5:0] s, logic me, logic bc);
      @(negedge mclk);
      cmd_kind = k;
      {cmd_valid, port1_comm_valid, cmd_suffix, cmd_to_me, cmd_broadcast} = {2'b11, s, me, bc};
      if ((k == msc_pkg::MSC_CMD_MEASURE && me) || (k != msc_pkg::MSC_CMD_MEASURE
         && k < msc_pkg::MSC_CMD_SLEEP && (me || bc))) exp_cnt++;
      @(negedge mclk);
      {cmd_valid, port1_comm_valid} = 2'b00;
   endtask : cmd
   task automatic rd(logic [1:0] p, logic [5:0] a, output logic [13:0] d);
      @(negedge mclk);
      {rd_en, rd_page, rd_addr} = {1'b1, p, a};
      @(negedge mclk);
      rd_en = 0;
      d = rd_data;
   endtask : rd
   task automatic wr(logic [5:0] a, logic [13:0] d);
      @(negedge mclk);
      {wr_en, wr_page, wr_addr, wr_data} = {1'b1, msc_pkg::PAGE_CFG, a, d};
      @(negedge mclk);
      wr_en = 0;
   endtask : wr
   task automatic idle();
      seen = 0;
      for (int i = 0; i < 300 && (i < 3 || op_busy !== 1'b0); i++) begin
         @(negedge mclk);
         if (thermistor_bias_output === 1'b1) seen = 1;
      end
   endtask : idle
   task automatic to_sleep(logic run);
      link_run = run;
      cmd(msc_pkg::MSC_CMD_SLEEP, 6'h0, 0, 1);
      for (t0 = 0; t0 < 400 && sleep_mode !== 1'b1; t0++) @(negedge mclk);
   endtask : to_sleep
   task automatic close_out();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      close_out();
   end
   initial begin
      repeat (10) @(negedge mclk);
      resetn = 1;
      foreach (rows[i]) begin
         t0 = n_start;
         cmd(msc_pkg::MSC_CMD_MEASURE, rows[i].sfx, 1, 0);
         idle();
         `CHK("starts", int'(rows[i].ok), n_start - t0)
         if (rows[i].sfx != 6'h10) `CHK("bias", rows[i].bias, seen)
         rd(msc_pkg::PAGE_RESULT, rows[i].sfx, v);
         if (rows[i].ok) `CHK("result", {rows[i].sfx, 8'h5a}, v)
         rd(msc_pkg::PAGE_CFG, msc_pkg::ADDR_RCPT_CNT, v);
         `CHK("count", 14'(exp_cnt), v)
         $display("row %0d done", i);
      end
      t0 = n_start;
      cmd(msc_pkg::MSC_CMD_MEASURE, 6'h01, 1, 0);
      cmd(msc_pkg::MSC_CMD_MEASURE, 6'h02, 1, 0);
      idle();
      `CHK("busy starts", 1, n_start - t0)
      for (int k = 1; k < 5; k++) begin
         cmd(msc_pkg::msc_cmd_t'(k), 6'h0, 0, 1);
         if (k != 2) `CHK("scan", {1'b1, 3'(k)}, {scan_start, scan_kind})
         idle();
      end
      wr(msc_pkg::ADDR_TEMP_CHK, 14'h1);
      t0 = n_start;
      cmd(msc_pkg::MSC_CMD_SCAN_TEMP, 6'h0, 0, 1);
      idle();
      `CHK("temp starts", 4, n_start - t0)
      `CHK("bias off", 1'b0, thermistor_bias_output)
      `CHK("fault", 4'h1, temp_fault)
      rd(msc_pkg::PAGE_RESULT, 6'h12, v);
      `CHK("ext2", {6'h12, 8'h5a}, v)
      wr(msc_pkg::ADDR_TEMP_FLT, 14'h1);
      wr(msc_pkg::ADDR_RCPT_CNT, 14'h3);
      rd(msc_pkg::PAGE_CFG, msc_pkg::ADDR_RCPT_CNT, v);
      `CHK("wrapped count", 14'(exp_cnt), v)
      `CHK("fault clr", 4'h0, temp_fault)
      $display("measure and scan tests done");
      cmd(msc_pkg::MSC_CMD_SLEEP, 6'h0, 1, 0);
      `CHK("nak", 3'b100, {resp_nak, resp_ack, sleep_pending})
      link_run = 1;
      cmd(msc_pkg::MSC_CMD_SLEEP, 6'h0, 0, 1);
      `CHK("ack", 4'b0110, {resp_nak, resp_ack, sleep_pending, comm_timeout_check_en})
      cmd(msc_pkg::MSC_CMD_OTHER, 6'h0, 0, 0);
      `CHK("cancel", 1'b0, sleep_pending)
      cmd(msc_pkg::MSC_CMD_SLEEP, 6'h0, 0, 1);
      repeat (40) @(negedge mclk);
      to_sleep(1);
      `CHK("restart wait", 1'b1, t0 >= 50 && t0 <= 80)
      `CHK("asleep", 2'b10, {sleep_mode, main_power_en})
      cmd(msc_pkg::MSC_CMD_WAKEUP, 6'h0, 1, 0);
      `CHK("stay asleep", 1'b1, sleep_mode)
      cmd(msc_pkg::MSC_CMD_WAKEUP, 6'h0, 0, 1);
      `CHK("awake", 1'b0, sleep_mode)
      to_sleep(0);
      `CHK("max wait", 1'b1, t0 >= 295 && t0 <= 305)
      cmd(msc_pkg::MSC_CMD_WAKEUP, 6'h0, 0, 1);
      @(negedge mclk);
      watchdog_expired = 1;
      @(negedge mclk);
      watchdog_expired = 0;
      `CHK("watchdog", 1'b1, sleep_mode)
      $display("sleep tests done");
      resetn = 0;
      repeat (2) @(negedge mclk);
      resetn = 1;
      `CHK("reset outs", 3'b011, {sleep_mode, main_power_en, comm_timeout_check_en})
      rd(msc_pkg::PAGE_CFG, msc_pkg::ADDR_RCPT_CNT, v);
      `CHK("reset count", 14'h0, v)
      rd(msc_pkg::PAGE_CFG, msc_pkg::ADDR_TEMP_CHK, v);
      `CHK("reset enables", 14'h0, v)
      $display("reset test done");
      close_out();
   end
endmodule : msc_measure_sleep_command_logic_tb_top
